//--- hdl/scsd_pkg.sv
// Purpose: constants and types for the serial clock select and decode block
// Assumes: 24-bit processor address, 16-bit processor data
// Notes: chip selects and strobes are active low at the ports
package scsd_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  // address field positions
  localparam int A_TOP_HI = 23;
  localparam int A_TOP_LO = 20;
  localparam int A_IO_LO = 22;
  localparam int A_GEN_LO = 21;
  localparam int A_MISC_HI = 19;
  localparam int A_SUB_HI = 18;
  localparam int A_SUB_LO = 16;
  localparam int A_LAT_HI = 14;
  localparam int A_LAT_LO = 12;
  localparam int A_SER_HI = 2;
  localparam int A_SER_LO = 1;
  localparam int D_CLKSEL = 12;
  localparam int D_LATVAL = 15;
  // decode patterns
  localparam logic [1:0] IO_SPACE = 2'h3;
  localparam logic [3:0] MISC_SUB = 4'hA;
  localparam logic [3:0] PERIPH_TOP = 4'hE;
  localparam logic [2:0] GEN_TOP = 3'h7;
  localparam logic [2:0] SER_SUB = 3'h5;
  localparam logic [2:0] MODEM_SUB = 3'h6;
  localparam logic [2:0] GEN_SUB = 3'h4;
  // latch output indices
  localparam logic [2:0] LAT_LINE_ONE = 3'h4;
  localparam logic [2:0] LAT_LINE_TWO = 3'h5;
  localparam logic [2:0] LAT_DIAL_NET = 3'h7;
  // register byte addresses
  localparam logic [23:0] CHAN_A_DATA = 24'hE50000;
  localparam logic [23:0] CHAN_B_DATA = 24'hE50002;
  localparam logic [23:0] CHAN_A_STATUS_COMMAND = 24'hE50004;
  localparam logic [23:0] CHAN_B_STATUS_COMMAND = 24'hE50006;
  localparam logic [23:0] MODEM_LINE_CONTROL = 24'hE60000;
  localparam logic [23:0] MODEM_RELAY_LAMP = 24'hE63000;
  localparam logic [23:0] MODEM_ANSWER_OPTIONS = 24'hE64000;
  localparam logic [23:0] MODEM_DISCONNECT_OPTIONS = 24'hE65000;
  localparam logic [23:0] MODEM_DATAPATH_TEST = 24'hE66000;
  localparam logic [23:0] TRANSCEIVER_CONTROL_ONE = 24'hE68000;
  localparam logic [23:0] TRANSCEIVER_CONTROL_TWO = 24'hE69000;
  localparam logic [23:0] TRANSCEIVER_STATUS = 24'hE6A000;
  localparam logic [23:0] XCVR_MASK = 24'hFFF000;
  // serial controller register selects (a2,a1)
  localparam logic [1:0] SER_A_DATA = 2'h0;
  localparam logic [1:0] SER_B_DATA = 2'h1;
  localparam logic [1:0] SER_A_CTRL = 2'h2;
  localparam logic [1:0] SER_B_CTRL = 2'h3;
  // clock switch states, one-hot
  typedef enum logic [2:0] {
    SW_RUN = 3'h1,
    SW_WAIT = 3'h2,
    SW_SWAP = 3'h4
  } scsd_sw_state_type;
  // processor bus request
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic strobe;
    logic write;
  } scsd_bus_type;
  // decoded selects
  typedef struct packed {
    logic serialSel;
    logic modemSel;
    logic miscWrite;
    logic genWrite;
    logic xcvrCtrlOne;
    logic xcvrCtrlTwo;
    logic xcvrStatus;
  } scsd_sel_type;
endpackage

//--- hdl/scsd_serial_clock_select.sv
// Purpose: serial channel clock selection, address decode and line-select latch
// Assumes: inputs synchronous to clk; serial clocks far slower than clk
// Notes: all outputs registered; chip selects and strobes active low

// Summary of operation
// R1 - each channel selects its clock source independently of the other
// R2 - channel A clocks come from port clocks or baud generator, one mux per direction
// R3 - channel B terminal-ready low picks port clocks, high picks baud generator
// R4 - channel B clocks come from modem clocks or fixed 19.2K source
// R5 - channel B select bit zero picks modem clocks, one picks 19.2K source
// R6 - channel B select bit loads from data bit 12 on misc register write
// R7 - misc write: a23,a22 high, a21,a20 ignored, a19..a16 = 1010
// R8 - serial controller select: a23..a20 = 1110, a19 ignored, a18..a16 = 101
// R9 - modem select: a23..a20 = 1110, a19 ignored, a18..a16 = 110
// R10 - a23 and a22 form an i/o enable qualifying peripheral selects
// R11 - serial window: data at E50000/E50002, status/command at E50004/E50006
// R12 - transceiver controls at E68000, E69000 and status at E6A000
// R13 - processor writes modem setup to its write-only locations
// R14 - processor loads modem setup first, then sends data over channel B
// R15 - general control write sets latch output a14..a12 to data bit 15
// R16 - general control write: a23..a21 high, a20,a19 ignored, a18..a16 = 100
// R17 - latch index 100 line one, 101 line two, 111 dial-network connect
// R18 - channel B select and latch outputs clear on reset
// R19 - clock muxes switch only while both candidate clocks are low
module scsd_serial_clock_select (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // processor bus
  input wire logic [23:0] procAddr,
  input wire logic [15:0] procData,
  input wire logic procStrobe,
  input wire logic procWrite,
  // clock sources
  input wire logic port_ext_tx_clock,
  input wire logic port_ext_rx_clock,
  input wire logic prog_baud_out,
  input wire logic line_unit_tx_clock,
  input wire logic line_unit_rx_clock,
  input wire logic fixedBaudClock,
  input wire logic chanBTermReady,
  // serial controller clocks
  output logic chan_a_tx_clock,
  output logic chan_a_rx_clock,
  output logic chan_b_tx_clock,
  output logic chan_b_rx_clock,
  // decoded selects
  output logic serialSelect_n,
  output logic [1:0] serialRegSel,
  output logic modemSelect_n,
  output logic misc_reg_write_n,
  output logic gen_ctrl_write_n,
  output logic xcvrCtrlOneWrite_n,
  output logic xcvrCtrlTwoWrite_n,
  output logic xcvrStatusRead_n,
  output logic io_space_enable,
  // control outputs
  output logic chan_b_clk_select_n,
  output logic line_one_select,
  output logic line_two_select,
  output logic dialNetConnect
);

  scsd_pkg::scsd_bus_type bus;
  scsd_pkg::scsd_sel_type sel;
  logic clkSelBit_reg;
  logic [7:0] latch_reg;
  logic [3:0] clkIn;
  logic [3:0] clkAlt;
  logic [3:0] want;
  logic [3:0] clkOut_reg;

  assign bus = '{addr: procAddr, data: procData, strobe: procStrobe, write: procWrite};

  // address window decoders
  function automatic logic ioSpace(input logic [23:0] a);
    ioSpace = (a[scsd_pkg::A_TOP_HI:scsd_pkg::A_IO_LO] == scsd_pkg::IO_SPACE); // R10
  endfunction

  function automatic logic periph(input logic [23:0] a, input logic [2:0] sub);
    periph = ioSpace(a)
      && (a[scsd_pkg::A_TOP_HI:scsd_pkg::A_TOP_LO] == scsd_pkg::PERIPH_TOP)
      && (a[scsd_pkg::A_SUB_HI:scsd_pkg::A_SUB_LO] == sub);
  endfunction

  function automatic logic xcvrHit(input logic [23:0] a, input logic [23:0] base);
    xcvrHit = ioSpace(a) && ((a & scsd_pkg::XCVR_MASK) == base); // R12
  endfunction

  always_comb begin
    sel.serialSel = periph(bus.addr, scsd_pkg::SER_SUB); // R8
    sel.modemSel = periph(bus.addr, scsd_pkg::MODEM_SUB); // R9
    sel.miscWrite = ioSpace(bus.addr) && bus.write
      && (bus.addr[scsd_pkg::A_MISC_HI:scsd_pkg::A_SUB_LO] == scsd_pkg::MISC_SUB); // R7
    sel.genWrite = ioSpace(bus.addr) && bus.write
      && (bus.addr[scsd_pkg::A_TOP_HI:scsd_pkg::A_GEN_LO] == scsd_pkg::GEN_TOP)
      && (bus.addr[scsd_pkg::A_SUB_HI:scsd_pkg::A_SUB_LO] == scsd_pkg::GEN_SUB); // R16
    sel.xcvrCtrlOne = bus.write && xcvrHit(bus.addr, scsd_pkg::TRANSCEIVER_CONTROL_ONE);
    sel.xcvrCtrlTwo = bus.write && xcvrHit(bus.addr, scsd_pkg::TRANSCEIVER_CONTROL_TWO);
    sel.xcvrStatus = !bus.write && xcvrHit(bus.addr, scsd_pkg::TRANSCEIVER_STATUS);
  end

  // serial controller select
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serialSelect_n <= 1'b1;
    end else begin
      serialSelect_n <= !(bus.strobe && sel.serialSel); // R8
    end
  end

  // serial controller register select
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serialRegSel <= 2'h0;
    end else begin
      serialRegSel <= bus.addr[scsd_pkg::A_SER_HI:scsd_pkg::A_SER_LO]; // R11
    end
  end

  // modem select
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modemSelect_n <= 1'b1;
    end else begin
      modemSelect_n <= !(bus.strobe && sel.modemSel); // R9 R13
    end
  end

  // misc register write strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      misc_reg_write_n <= 1'b1;
    end else begin
      misc_reg_write_n <= !(bus.strobe && sel.miscWrite); // R7
    end
  end

  // general control write strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gen_ctrl_write_n <= 1'b1;
    end else begin
      gen_ctrl_write_n <= !(bus.strobe && sel.genWrite); // R16
    end
  end

  // transceiver control one write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xcvrCtrlOneWrite_n <= 1'b1;
    end else begin
      xcvrCtrlOneWrite_n <= !(bus.strobe && sel.xcvrCtrlOne); // R12
    end
  end

  // transceiver control two write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xcvrCtrlTwoWrite_n <= 1'b1;
    end else begin
      xcvrCtrlTwoWrite_n <= !(bus.strobe && sel.xcvrCtrlTwo); // R12
    end
  end

  // transceiver status read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xcvrStatusRead_n <= 1'b1;
    end else begin
      xcvrStatusRead_n <= !(bus.strobe && sel.xcvrStatus); // R12
    end
  end

  // i/o space enable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      io_space_enable <= 1'b0;
    end else begin
      io_space_enable <= bus.strobe && ioSpace(bus.addr); // R10
    end
  end

  // channel B clock select bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clkSelBit_reg <= 1'b0; // R18
    end else if (bus.strobe && sel.miscWrite) begin
      clkSelBit_reg <= bus.data[scsd_pkg::D_CLKSEL]; // R6
    end
  end

  // addressable latch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_reg <= 8'h00; // R18
    end else if (bus.strobe && sel.genWrite) begin
      latch_reg[bus.addr[scsd_pkg::A_LAT_HI:scsd_pkg::A_LAT_LO]] <=
        bus.data[scsd_pkg::D_LATVAL]; // R15
    end
  end

  // channel B clock select output
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chan_b_clk_select_n <= 1'b1; // R18
    end else begin
      chan_b_clk_select_n <= !clkSelBit_reg; // R5
    end
  end

  // line one select output
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_one_select <= 1'b0; // R18
    end else begin
      line_one_select <= latch_reg[scsd_pkg::LAT_LINE_ONE]; // R17
    end
  end

  // line two select output
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_two_select <= 1'b0; // R18
    end else begin
      line_two_select <= latch_reg[scsd_pkg::LAT_LINE_TWO]; // R17
    end
  end

  // dial network connect output
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dialNetConnect <= 1'b0; // R18
    end else begin
      dialNetConnect <= latch_reg[scsd_pkg::LAT_DIAL_NET]; // R17
    end
  end

  // mux inputs: index 0 a-tx, 1 a-rx, 2 b-tx, 3 b-rx
  assign clkIn = {line_unit_rx_clock, line_unit_tx_clock, port_ext_rx_clock, port_ext_tx_clock};
  assign clkAlt = {fixedBaudClock, fixedBaudClock, prog_baud_out, prog_baud_out}; // R2 R4
  assign want = {clkSelBit_reg, clkSelBit_reg, chanBTermReady, chanBTermReady}; // R1 R3 R5

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_mux
      scsd_pkg::scsd_sw_state_type state_reg;
      logic useAlt_reg;

      // switch sequencer
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          state_reg <= scsd_pkg::SW_RUN;
        end else begin
          case (state_reg)
            scsd_pkg::SW_RUN: begin
              if (want[g] != useAlt_reg) begin
                state_reg <= scsd_pkg::SW_WAIT;
              end
            end
            scsd_pkg::SW_WAIT: begin
              if (want[g] == useAlt_reg) begin
                state_reg <= scsd_pkg::SW_RUN;
              end else if (!clkIn[g] && !clkAlt[g]) begin
                state_reg <= scsd_pkg::SW_SWAP; // R19
              end
            end
            scsd_pkg::SW_SWAP: begin
              state_reg <= scsd_pkg::SW_RUN;
            end
            default: begin
              state_reg <= scsd_pkg::SW_RUN;
            end
          endcase
        end
      end

      // chosen source, changed only in the swap state
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          useAlt_reg <= 1'b0;
        end else if (state_reg == scsd_pkg::SW_SWAP) begin
          useAlt_reg <= want[g]; // R19
        end
      end

      // muxed clock, held low while switching
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          clkOut_reg[g] <= 1'b0;
        end else if (state_reg == scsd_pkg::SW_RUN) begin
          clkOut_reg[g] <= useAlt_reg ? clkAlt[g] : clkIn[g]; // R2 R4
        end else begin
          clkOut_reg[g] <= 1'b0; // R19
        end
      end
    end
  endgenerate

  assign chan_a_tx_clock = clkOut_reg[0];
  assign chan_a_rx_clock = clkOut_reg[1];
  assign chan_b_tx_clock = clkOut_reg[2];
  assign chan_b_rx_clock = clkOut_reg[3];

endmodule

//--- testbench/scsd_serial_clock_select_sva.sv
// Purpose: port checks for the serial clock select and decode block
// Assumes: bound to the top module, one clock domain
// Notes: selects are registered one cycle behind the strobe
module scsd_serial_clock_select_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // processor bus
  input wire logic [23:0] procAddr,
  input wire logic [15:0] procData,
  input wire logic procStrobe,
  input wire logic procWrite,
  // clocks
  input wire logic port_ext_tx_clock,
  input wire logic prog_baud_out,
  input wire logic chan_a_tx_clock,
  // decoded outputs
  input wire logic serialSelect_n,
  input wire logic modemSelect_n,
  input wire logic misc_reg_write_n,
  input wire logic gen_ctrl_write_n,
  input wire logic xcvrCtrlOneWrite_n,
  input wire logic io_space_enable,
  input wire logic chan_b_clk_select_n,
  input wire logic line_one_select,
  input wire logic line_two_select,
  input wire logic dialNetConnect
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ioHit;
  logic miscHit;
  logic perHit;
  logic genHit;
  assign ioHit = procStrobe && (procAddr[23:22] == 2'h3);
  assign miscHit = ioHit && procWrite && (procAddr[19:16] == 4'hA);
  assign perHit = procStrobe && (procAddr[23:20] == 4'hE);
  assign genHit = procStrobe && procWrite && (procAddr[23:21] == 3'h7)
    && (procAddr[18:16] == 3'h4);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_IOEN: assert property (1'b1 |=> io_space_enable == $past(ioHit))
    else $error("io enable wrong");
  AST_MISC: assert property (1'b1 |=> misc_reg_write_n != $past(miscHit))
    else $error("misc strobe wrong");
  AST_SER: assert property (perHit && procAddr[18:16] == 3'h5 |=> !serialSelect_n)
    else $error("serial select missing");
  AST_MODEM: assert property (perHit && procAddr[18:16] == 3'h6 |=> !modemSelect_n)
    else $error("modem select missing");
  AST_NOSEL: assert property (!perHit |=> serialSelect_n && modemSelect_n)
    else $error("select outside window");
  AST_GEN: assert property (1'b1 |=> gen_ctrl_write_n != $past(genHit))
    else $error("general strobe wrong");
  AST_XCVR: assert property (procStrobe && procWrite
    && procAddr[23:12] == 12'hE68 |=> !xcvrCtrlOneWrite_n)
    else $error("transceiver strobe missing");
  AST_CLKSEL: assert property (miscHit
    |-> ##2 chan_b_clk_select_n != $past(procData[12], 2))
    else $error("clock select bit wrong");
  AST_LINE: assert property (genHit && procAddr[14:12] == 3'h4
    |-> ##2 line_one_select == $past(procData[15], 2))
    else $error("line one latch wrong");
  AST_DIAL: assert property (genHit && procAddr[14:12] == 3'h7
    |-> ##2 dialNetConnect == $past(procData[15], 2))
    else $error("dial latch wrong");
  AST_AMUX: assert property ($rose(chan_a_tx_clock) |-> $past(port_ext_tx_clock) || $past(prog_baud_out))
    else $error("runt on channel A clock");
  AST_RESET: assert property (disable iff (1'b0) reset && $past(reset)
    |-> chan_b_clk_select_n && !line_one_select && !line_two_select && !dialNetConnect)
    else $error("reset state wrong");
endmodule

bind scsd_serial_clock_select scsd_serial_clock_select_sva i_sva (.clk(clk), .reset(reset),
  .procAddr(procAddr), .procData(procData), .procStrobe(procStrobe), .procWrite(procWrite),
  .port_ext_tx_clock(port_ext_tx_clock), .prog_baud_out(prog_baud_out),
  .chan_a_tx_clock(chan_a_tx_clock), .serialSelect_n(serialSelect_n),
  .modemSelect_n(modemSelect_n), .misc_reg_write_n(misc_reg_write_n),
  .gen_ctrl_write_n(gen_ctrl_write_n), .xcvrCtrlOneWrite_n(xcvrCtrlOneWrite_n),
  .io_space_enable(io_space_enable), .chan_b_clk_select_n(chan_b_clk_select_n),
  .line_one_select(line_one_select), .line_two_select(line_two_select),
  .dialNetConnect(dialNetConnect));

//--- testbench/scsd_clock_source_model.sv
// Purpose: far-side clock sources for the serial clock select block
// Assumes: all sources are free-running dividers of clk
// Notes: distinct periods within each mux pair so a wrong mux choice shows within 64 cycles
module scsd_clock_source_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // port tx, port rx, baud, modem tx, modem rx, fixed
  output logic [5:0] srcClocks
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tick;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick <= 8'h00;
    end else begin
      tick <= tick + 8'h01;
    end
  end
  assign srcClocks = {tick[4], tick[5], tick[3], tick[5], tick[6], tick[2]};
endmodule

//--- testbench/test_scsd_serial_clock_select.sv
// Purpose: self-checking bench for the serial clock select and decode block
// Assumes: 200 MHz clock, reset held 20 cycles
// Notes: selects compared at the falling edge after the taking edge
module test_scsd_serial_clock_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic termReady = 1'b0;
  scsd_pkg::scsd_bus_type bus = '0;
  logic [5:0] src;
  logic [5:0] srcPrev = 6'h00;
  logic [3:0] muxOut;
  logic [9:0] selOut;
  logic [3:0] ctl;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  localparam logic [24:0] TBL [20] = '{25'h0E50000, 25'h1E50002, 25'h1E50004, 25'h0E58006,
    25'h1E60000, 25'h1E63000, 25'h1E64000, 25'h1E65000, 25'h1E66000, 25'h1E68000, 25'h1E69000,
    25'h0E6A000, 25'h1E6A000, 25'h1CA0000, 25'h1FA0000, 25'h0CA0000, 25'h1E40000, 25'h1FC0000,
    25'h1000000, 25'h0D50000};
  always #2.5 clk = ~clk;
  always @(posedge clk) srcPrev <= src;
  scsd_clock_source_model i_src (.clk(clk), .reset(reset), .srcClocks(src));
  scsd_serial_clock_select i_dut (.clk(clk), .reset(reset), .procAddr(bus.addr),
    .procData(bus.data), .procStrobe(bus.strobe), .procWrite(bus.write),
    .port_ext_tx_clock(src[5]), .port_ext_rx_clock(src[4]), .prog_baud_out(src[3]),
    .line_unit_tx_clock(src[2]), .line_unit_rx_clock(src[1]), .fixedBaudClock(src[0]),
    .chanBTermReady(termReady), .chan_a_tx_clock(muxOut[3]), .chan_a_rx_clock(muxOut[2]),
    .chan_b_tx_clock(muxOut[1]), .chan_b_rx_clock(muxOut[0]), .serialSelect_n(selOut[9]),
    .serialRegSel(selOut[8:7]), .modemSelect_n(selOut[6]), .misc_reg_write_n(selOut[5]),
    .gen_ctrl_write_n(selOut[4]), .xcvrCtrlOneWrite_n(selOut[3]),
    .xcvrCtrlTwoWrite_n(selOut[2]), .xcvrStatusRead_n(selOut[1]),
    .io_space_enable(selOut[0]), .chan_b_clk_select_n(ctl[3]), .line_one_select(ctl[2]),
    .line_two_select(ctl[1]), .dialNetConnect(ctl[0]));
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [9:0] decode(input logic [23:0] a, input logic w);
    logic per;
    logic io;
    per = a[23:20] == 4'hE;
    io = a[23:22] == 2'h3;
    decode = {!(per && a[18:16] == 3'h5), a[2:1], !(per && a[18:16] == 3'h6),
      !(io && w && a[19:16] == 4'hA), !(w && a[23:21] == 3'h7 && a[18:16] == 3'h4),
      !(w && a[23:12] == 12'hE68), !(w && a[23:12] == 12'hE69), !(!w && a[23:12] == 12'hE6A), io};
  endfunction
  task automatic access(input logic [23:0] a, input logic [15:0] d, input logic w);
    @(posedge clk);
    bus <= '{addr: a, data: d, strobe: 1'b1, write: w};
    @(posedge clk);
    bus.strobe <= 1'b0;
    @(negedge clk);
    cmp(selOut, decode(a, w));
  endtask
  task automatic check_decode();
    for (int i = 0; i < 20; i++) begin
      access(TBL[i][23:0], 16'h0000, TBL[i][24]);
    end
  endtask
  task automatic check_latch();
    logic [2:0] idx;
    logic [2:0] exp;
    exp = 3'h0;
    for (int i = 0; i < 4; i++) begin
      idx = (i == 3) ? 3'h4 : 3'h4 + i[2:0] + (i == 2);
      access({i[0] ? 8'hFC : 8'hE4, 1'b0, idx, 12'h000}, {i < 3, 15'h0000}, 1'b1);
      if (idx == 3'h4) begin
        exp[2] = i < 3;
      end else if (idx == 3'h5) begin
        exp[1] = i < 3;
      end else begin
        exp[0] = i < 3;
      end
      @(negedge clk);
      cmp(ctl[2:0], exp);
    end
  endtask
  task automatic check_clocks();
    logic [2:0] k;
    for (int j = 0; j < 5; j++) begin
      k = j[2:0] & 3'h3;
      @(posedge clk);
      termReady <= k[0];
      access(24'hCA0000, {3'h0, k[1], 12'h000}, 1'b1);
      repeat (300) @(negedge clk);
      cmp(ctl[3], !k[1]);
      repeat (64) begin
        @(negedge clk);
        cmp(muxOut, {k[0] ? srcPrev[3] : srcPrev[5], k[0] ? srcPrev[3] : srcPrev[4],
          k[1] ? srcPrev[0] : srcPrev[2], k[1] ? srcPrev[0] : srcPrev[1]});
      end
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    cmp({selOut, ctl}, {10'h27E, 4'h8});
    @(posedge clk);
    reset <= 1'b0;
    check_decode();
    check_latch();
    check_clocks();
    print_verdict();
  end
endmodule
